// file: pkg/csgp_pkg.sv
package csgp_pkg;
    // coprocessor transfer encodings
    localparam logic [3:0] CSGP_COPROC_SYS  = 4'hf;
    localparam logic [3:0] CSGP_OPC1_GRP1   = 4'h0;
    localparam logic [3:0] CSGP_OPC1_GRP0   = 4'h2;
    localparam logic [3:0] CSGP_CRM_GEN     = 4'hc;
    // field positions of the generate value
    localparam int CSGP_ID_LO   = 24;
    localparam int CSGP_AFFINITY_LEVEL_ONE_LO = 16;
    localparam int CSGP_AFFINITY_LEVEL_TWO_LO = 32;
    localparam int CSGP_AFFINITY_LEVEL_THREE_LO = 48;
    localparam int CSGP_ROUTE_POS = 40;
    localparam int CSGP_ID_W    = 4;
    localparam int CSGP_AFF_W   = 8;
    localparam int CSGP_TGT_W   = 16;
    // exception levels
    localparam logic [1:0] CSGP_EL1 = 2'h1;
    localparam logic [1:0] CSGP_EL2 = 2'h2;
    localparam logic [1:0] CSGP_EL3 = 2'h3;

    // outcome of an access check
    typedef enum logic [2:0] {
        CSGP_OK    = 3'h0,
        CSGP_TRAP2 = 3'h1,
        CSGP_TRAP3 = 3'h3,
        CSGP_UNDEF = 3'h2
    } csgp_result_t;

    // access request from the pipeline
    typedef struct packed {
        logic        valid;
        logic        is_enable_reg;
        logic [3:0]  coproc;
        logic [3:0]  opc1;
        logic [3:0]  crm;
        logic [1:0]  el;
        logic        nonsecure;
        logic [63:0] data;
    } csgp_req_t;

    // trap and enable controls
    typedef struct packed {
        logic hyp_fiq_route_bit;
        logic hyp_irq_route_bit;
        logic hyp_common_trap_bit;
        logic hyp_sysreg_trap_bit;
        logic monitor_fiq_route_bit;
        logic monitor_irq_route_bit;
        logic sysreg_enable_el1;
        logic sysreg_enable_el2;
        logic sysreg_enable_el3;
        logic enable_el2;
        logic enable_el3;
        logic redistributor_nonsecure_access_control;
    } csgp_ctrl_t;

    // generate packet to the distributor
    typedef struct packed {
        logic        valid;
        logic        group1;
        logic        nonsecure;
        logic [3:0]  interrupt_identifier;
        logic [7:0]  affinity_level_three;
        logic [7:0]  affinity_level_two;
        logic [7:0]  affinity_level_one;
        logic        routing_mode_bit;
        logic [15:0] target_mask;
    } csgp_pkt_t;

    typedef struct packed {
        csgp_pkt_t    pkt;
        logic         done;
        csgp_result_t result;
    } csgp_state_t;
endpackage

// file: hdl/csgp_top.sv
`timescale 1ns/1ps
// Operation
// - identifier from bits 27:24 into packet
// - affinity path from three byte fields
// - bits 15:0 form the target mask
// - bit 40 selects targeted or broadcast
// - targeted reach limited to sixteen elements
// - group one write gives writer's group
// - group zero write secure, nonsecure gated
// - 64-bit write-only, one transfer
// - group one encoding opc1 0000 crm 1100
// - group zero encoding opc1 0010 crm 1100
// - hyp routing or common trap to two
// - hyp sysreg trap bit traps nonsecure one
// - cleared enable at level makes undefined
// - monitor routing traps two and secure one
// - monitor routing, no hyp routing, trap three
// - enable register selects sysreg or memory view; here its accesses are only trap-checked, never select a view
// - level two enable clear traps to two
// - level three enable clear traps to three
module csgp_top
    import csgp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire csgp_req_t  req,
    input  wire csgp_ctrl_t ctrl,
    output csgp_pkt_t       pkt,
    output logic            done,
    output csgp_result_t    result
);

    csgp_state_t state_reg;
    csgp_state_t state_next;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic is_generate(input csgp_req_t  r,
                                         input logic [3:0] o);
        is_generate = (r.coproc == CSGP_COPROC_SYS) && (r.opc1 == o) &&
                      (r.crm == CSGP_CRM_GEN) && !r.is_enable_reg;
    endfunction

    // enable bit that governs the writer's exception level
    function automatic logic sysreg_enabled(input csgp_ctrl_t c,
                                            input logic [1:0] el);
        unique case (el)
            CSGP_EL2: sysreg_enabled = c.sysreg_enable_el2;
            CSGP_EL3: sysreg_enabled = c.sysreg_enable_el3;
            default:  sysreg_enabled = c.sysreg_enable_el1;
        endcase
    endfunction

    logic         hit_g0;
    logic         hit_g1;
    logic         ns_el1;
    logic         mon_route;
    logic         hyp_route;
    logic         g0_denied;
    csgp_result_t gen_res;
    csgp_result_t en_res;

    ////////////////////////////////////////////////////////////////////////
    // access checks
    always_comb begin
        hit_g1    = is_generate(req, CSGP_OPC1_GRP1);
        hit_g0    = is_generate(req, CSGP_OPC1_GRP0);
        ns_el1    = req.nonsecure && (req.el == CSGP_EL1);
        mon_route = ctrl.monitor_fiq_route_bit && ctrl.monitor_irq_route_bit;
        hyp_route = ctrl.hyp_fiq_route_bit || ctrl.hyp_irq_route_bit;
        g0_denied = req.nonsecure && (req.el != CSGP_EL3) &&
                    !ctrl.redistributor_nonsecure_access_control;
        // generate register write checks, undefined first
        if (!sysreg_enabled(ctrl, req.el)) begin
            gen_res = CSGP_UNDEF;
        end else if (ns_el1 && (hyp_route || ctrl.hyp_common_trap_bit ||
                                ctrl.hyp_sysreg_trap_bit)) begin
            gen_res = CSGP_TRAP2;
        end else if (mon_route && ns_el1 && !hyp_route) begin
            gen_res = CSGP_TRAP3;
        end else if (mon_route && ((req.el == CSGP_EL2) ||
                     (req.el == CSGP_EL1 && !req.nonsecure))) begin
            gen_res = CSGP_TRAP3;
        end else begin
            gen_res = CSGP_OK;
        end
        // level one enable register access checks
        if (ns_el1 && ctrl.hyp_sysreg_trap_bit) begin
            en_res = CSGP_TRAP2;
        end else if (ns_el1 && !ctrl.enable_el2) begin
            en_res = CSGP_TRAP2;
        end else if (!ctrl.enable_el3 && (req.el == CSGP_EL1 ||
                     req.el == CSGP_EL2)) begin
            en_res = CSGP_TRAP3;
        end else begin
            en_res = CSGP_OK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: packet formation
    always_comb begin
        state_next = state_reg;
        state_next.pkt.valid = 1'h0;
        state_next.done = 1'h0;
        if (req.valid) begin
            state_next.done = 1'h1;
            if (req.is_enable_reg) begin
                state_next.result = en_res;
            end else if (hit_g0 || hit_g1) begin
                state_next.result = gen_res;
                if (gen_res == CSGP_OK && !(hit_g0 && g0_denied)) begin
                    state_next.pkt = '0;
                    state_next.pkt.valid = 1'h1;
                    state_next.pkt.group1 = hit_g1;
                    state_next.pkt.nonsecure = hit_g1 && req.nonsecure;
                    state_next.pkt.interrupt_identifier =
                        req.data[CSGP_ID_LO +: CSGP_ID_W];
                    state_next.pkt.routing_mode_bit =
                        req.data[CSGP_ROUTE_POS];
                    if (!req.data[CSGP_ROUTE_POS]) begin
                        state_next.pkt.affinity_level_one =
                            req.data[CSGP_AFFINITY_LEVEL_ONE_LO +: CSGP_AFF_W];
                        state_next.pkt.affinity_level_two =
                            req.data[CSGP_AFFINITY_LEVEL_TWO_LO +: CSGP_AFF_W];
                        state_next.pkt.affinity_level_three =
                            req.data[CSGP_AFFINITY_LEVEL_THREE_LO +: CSGP_AFF_W];
                        state_next.pkt.target_mask =
                            req.data[CSGP_TGT_W-1:0];
                    end
                end
            end else begin
                state_next.result = CSGP_UNDEF;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; distributor always takes the packet
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pkt    = state_reg.pkt;
    assign done   = state_reg.done;
    assign result = state_reg.result;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_undef_blocks: assert property (@(posedge clk) disable iff (rst)
        (req.valid && (hit_g0 || hit_g1) && !sysreg_enabled(ctrl, req.el))
        |=> (result == CSGP_UNDEF && !pkt.valid))
        else $error("undefined write produced a packet");
    a_hyp_trap: assert property (@(posedge clk) disable iff (rst)
        (req.valid && hit_g1 && sysreg_enabled(ctrl, req.el) && ns_el1 &&
         hyp_route) |=> (result == CSGP_TRAP2))
        else $error("hyp routing did not trap to two");
    a_sysreg_trap: assert property (@(posedge clk) disable iff (rst)
        (req.valid && (hit_g0 || hit_g1) && sysreg_enabled(ctrl, req.el) &&
         ns_el1 && ctrl.hyp_sysreg_trap_bit) |=> (result == CSGP_TRAP2))
        else $error("sysreg trap bit ignored");
    a_mon_trap: assert property (@(posedge clk) disable iff (rst)
        (req.valid && hit_g1 && sysreg_enabled(ctrl, req.el) && mon_route &&
         req.el == CSGP_EL2) |=> (result == CSGP_TRAP3))
        else $error("monitor routing did not trap level two");
    a_id_field: assert property (@(posedge clk) disable iff (rst)
        pkt.valid |-> pkt.interrupt_identifier ==
            $past(req.data[CSGP_ID_LO +: CSGP_ID_W]))
        else $error("identifier mismatch");
    a_bcast_zero: assert property (@(posedge clk) disable iff (rst)
        (pkt.valid && pkt.routing_mode_bit) |->
        (pkt.target_mask == '0 && pkt.affinity_level_one == '0))
        else $error("broadcast packet carries targets");
    a_group_bit: assert property (@(posedge clk) disable iff (rst)
        pkt.valid |-> pkt.group1 == $past(hit_g1))
        else $error("packet group wrong");
    a_en2_trap: assert property (@(posedge clk) disable iff (rst)
        (req.valid && req.is_enable_reg && ns_el1 && !ctrl.enable_el2)
        |=> (result == CSGP_TRAP2 && done))
        else $error("enable register not trapped to two");
    a_g0_gate: assert property (@(posedge clk) disable iff (rst)
        (req.valid && hit_g0 && g0_denied) |=> !pkt.valid)
        else $error("denied group zero write sent");
    c_targeted: cover property (@(posedge clk) disable iff (rst)
        pkt.valid && !pkt.routing_mode_bit);
    c_broadcast: cover property (@(posedge clk) disable iff (rst)
        pkt.valid && pkt.routing_mode_bit);
    c_trap3: cover property (@(posedge clk) disable iff (rst)
        done && result == CSGP_TRAP3);
    c_grp0_sent: cover property (@(posedge clk) disable iff (rst)
        pkt.valid && !pkt.group1);
    c_undef: cover property (@(posedge clk) disable iff (rst)
        done && result == CSGP_UNDEF);

    ////////////////////////////////////////////////////////////////////////
    // helper terms for the checks below
    logic hit_any;
    logic wr_ok;
    assign hit_any = hit_g0 || hit_g1;
    assign wr_ok   = sysreg_enabled(ctrl, req.el);

    // packet fields follow the written value
    a_aff_one: assert property (@(posedge clk) disable iff (rst)
        (pkt.valid && !pkt.routing_mode_bit) |-> pkt.affinity_level_one ==
            $past(req.data[CSGP_AFFINITY_LEVEL_ONE_LO +: CSGP_AFF_W]))
        else $error("level one affinity mismatch");
    a_aff_two: assert property (@(posedge clk) disable iff (rst)
        (pkt.valid && !pkt.routing_mode_bit) |-> pkt.affinity_level_two ==
            $past(req.data[CSGP_AFFINITY_LEVEL_TWO_LO +: CSGP_AFF_W]))
        else $error("level two affinity mismatch");
    a_aff_three: assert property (@(posedge clk) disable iff (rst)
        (pkt.valid && !pkt.routing_mode_bit) |-> pkt.affinity_level_three ==
            $past(req.data[CSGP_AFFINITY_LEVEL_THREE_LO +: CSGP_AFF_W]))
        else $error("level three affinity mismatch");
    a_mask_field: assert property (@(posedge clk) disable iff (rst)
        (pkt.valid && !pkt.routing_mode_bit) |-> pkt.target_mask ==
            $past(req.data[CSGP_TGT_W-1:0]))
        else $error("target mask mismatch");
    a_route_field: assert property (@(posedge clk) disable iff (rst)
        pkt.valid |-> pkt.routing_mode_bit ==
            $past(req.data[CSGP_ROUTE_POS]))
        else $error("routing mode mismatch");
    a_bcast_upper: assert property (@(posedge clk) disable iff (rst)
        (pkt.valid && pkt.routing_mode_bit) |->
        (pkt.affinity_level_two == '0 && pkt.affinity_level_three == '0))
        else $error("broadcast packet carries upper affinity");

    // security state and group of the packet
    a_grp0_secure: assert property (@(posedge clk) disable iff (rst)
        (pkt.valid && !pkt.group1) |-> !pkt.nonsecure)
        else $error("group zero packet not secure");
    a_grp1_state: assert property (@(posedge clk) disable iff (rst)
        (pkt.valid && pkt.group1) |-> pkt.nonsecure == $past(req.nonsecure))
        else $error("group one packet has wrong security state");

    // trap outcomes of generate writes
    a_tc_trap: assert property (@(posedge clk) disable iff (rst)
        (req.valid && hit_any && wr_ok && ns_el1 &&
         ctrl.hyp_common_trap_bit) |=> (result == CSGP_TRAP2))
        else $error("common trap bit did not trap to two");
    a_mon_ns: assert property (@(posedge clk) disable iff (rst)
        (req.valid && hit_any && wr_ok && ns_el1 && mon_route &&
         !hyp_route && !ctrl.hyp_common_trap_bit &&
         !ctrl.hyp_sysreg_trap_bit) |=> (result == CSGP_TRAP3))
        else $error("nonsecure level one not trapped to three");
    a_mon_secure: assert property (@(posedge clk) disable iff (rst)
        (req.valid && hit_any && wr_ok && mon_route &&
         req.el == CSGP_EL1 && !req.nonsecure) |=> (result == CSGP_TRAP3))
        else $error("secure level one not trapped to three");
    a_el3_free: assert property (@(posedge clk) disable iff (rst)
        (req.valid && hit_any && wr_ok && req.el == CSGP_EL3)
        |=> (result == CSGP_OK))
        else $error("level three write was trapped");
    a_trap_nopkt: assert property (@(posedge clk) disable iff (rst)
        (done && result != CSGP_OK) |-> !pkt.valid)
        else $error("refused write produced a packet");
    a_bad_code: assert property (@(posedge clk) disable iff (rst)
        (req.valid && !req.is_enable_reg &&
         (req.coproc != CSGP_COPROC_SYS || req.crm != CSGP_CRM_GEN ||
          (req.opc1 != CSGP_OPC1_GRP1 && req.opc1 != CSGP_OPC1_GRP0)))
        |=> (result == CSGP_UNDEF && !pkt.valid))
        else $error("unknown encoding not undefined");

    // one answer per request, one cycle later
    a_done_pulse: assert property (@(posedge clk) disable iff (rst)
        done == $past(req.valid))
        else $error("done does not follow request");
    a_pkt_done: assert property (@(posedge clk) disable iff (rst)
        pkt.valid |-> done)
        else $error("packet without done");

    // level one enable register accesses
    a_en3_trap: assert property (@(posedge clk) disable iff (rst)
        (req.valid && req.is_enable_reg && !ns_el1 && !ctrl.enable_el3 &&
         (req.el == CSGP_EL1 || req.el == CSGP_EL2))
        |=> (result == CSGP_TRAP3))
        else $error("enable register not trapped to three");
    a_en_nopkt: assert property (@(posedge clk) disable iff (rst)
        (req.valid && req.is_enable_reg) |=> !pkt.valid)
        else $error("enable register access produced a packet");
endmodule

// file: bench/csgp_dist_model.sv
`timescale 1ns/1ps
// behavioural distributor, counts every generate packet it takes
module csgp_dist_model
    import csgp_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire csgp_pkt_t pkt,
    output int             received
);
    // never stalls; packets are only counted here, their fields are not examined
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            received <= 0;
        end else if (pkt.valid === 1'h1) begin
            received <= received + 1;
        end
    end
endmodule

// file: bench/csgp_top_tb.sv
`timescale 1ns/1ps
module csgp_top_tb
    import csgp_pkg::*;
;
    // reserved bits set to show they are dropped
    localparam logic [63:0] D  = 64'hffa5_fe5a_f7c3_bcc3;
    localparam logic [63:0] DB = 64'hffa5_ff5a_f7c3_bcc3;
    localparam csgp_pkt_t   PN = '0;
    logic         clk;
    logic         rst;
    csgp_req_t    req;
    csgp_ctrl_t   ctrl;
    csgp_pkt_t    pkt;
    logic         done;
    csgp_result_t result;
    int           received;
    int           num_errors;
    int           checked;
    int           issued;

    csgp_top u_csgp_top (.clk(clk), .rst(rst), .req(req), .ctrl(ctrl),
        .pkt(pkt), .done(done), .result(result));
    csgp_dist_model u_csgp_dist_model (.clk(clk), .rst(rst), .pkt(pkt),
        .received(received));

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic csgp_req_t mk(logic [1:0] el, logic ns, logic g1,
                                     logic en, logic [63:0] d);
        csgp_req_t r;
        r = '0;
        r.valid = 1'h1;
        r.is_enable_reg = en;
        r.coproc = CSGP_COPROC_SYS;
        r.opc1 = g1 ? CSGP_OPC1_GRP1 : CSGP_OPC1_GRP0;
        r.crm = CSGP_CRM_GEN;
        r.el = el;
        r.nonsecure = ns;
        r.data = d;
        return r;
    endfunction

    // expected packet worked out from the field layout
    function automatic csgp_pkt_t expk(logic g1, logic ns, logic [63:0] d);
        csgp_pkt_t p;
        p = '0;
        p.valid = 1'h1;
        p.group1 = g1;
        p.nonsecure = g1 & ns;
        p.interrupt_identifier = d[27:24];
        p.routing_mode_bit = d[40];
        if (!d[40]) begin
            p.affinity_level_three = d[55:48];
            p.affinity_level_two = d[39:32];
            p.affinity_level_one = d[23:16];
            p.target_mask = d[15:0];
        end
        return p;
    endfunction

    task automatic chk_res(input csgp_result_t er);
        checked++;
        if (done !== 1'h1 || result !== er) begin
            num_errors++;
            $display("[FAIL] %0t result %0d want %0d", $time, result, er);
        end
    endtask

    task automatic chk_pkt(input csgp_pkt_t ep);
        checked++;
        if ((ep.valid === 1'h0) ? (pkt.valid !== 1'h0) : (pkt !== ep)) begin
            num_errors++;
            $display("[FAIL] %0t packet %h want %h", $time, pkt, ep);
        end
    endtask

    task automatic chk_cnt(input int want);
        checked++;
        if (received !== want) begin
            num_errors++;
            $display("[FAIL] %0t distributor got %0d want %0d", $time,
                     received, want);
        end
    endtask

    // one request, judge the answer, then one idle cycle
    task automatic run(input csgp_ctrl_t c, input csgp_req_t r,
                       input csgp_result_t er, input csgp_pkt_t ep);
        @(posedge clk);
        ctrl <= c;
        req <= r;
        @(posedge clk);
        req.valid <= 1'h0;
        #1;
        chk_res(er);
        chk_pkt(ep);
        if (ep.valid) issued++;
    endtask

    task automatic trapx(input csgp_ctrl_t c, input logic [1:0] el,
                         input logic ns, input logic en,
                         input csgp_result_t er);
        run(c, mk(el, ns, 1'h1, en, D), er, PN);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_fields();
        run(12'h03e, mk(CSGP_EL1, 1'h0, 1'h1, 1'h0, D), CSGP_OK,
            expk(1'h1, 1'h0, D));
        run(12'h03e, mk(CSGP_EL2, 1'h1, 1'h1, 1'h0, D), CSGP_OK,
            expk(1'h1, 1'h1, D));
        run(12'h03e, mk(CSGP_EL3, 1'h0, 1'h1, 1'h0, DB), CSGP_OK,
            expk(1'h1, 1'h0, DB));
    endtask

    task automatic t_grp0();
        run(12'h03e, mk(CSGP_EL1, 1'h0, 1'h0, 1'h0, D), CSGP_OK,
            expk(1'h0, 1'h0, D));
        run(12'h03e, mk(CSGP_EL1, 1'h1, 1'h0, 1'h0, D), CSGP_OK, PN);
        run(12'h03f, mk(CSGP_EL1, 1'h1, 1'h0, 1'h0, D), CSGP_OK,
            expk(1'h0, 1'h1, D));
    endtask

    task automatic t_traps();
        trapx(12'h83e, CSGP_EL1, 1'h1, 1'h0, CSGP_TRAP2);
        trapx(12'h43e, CSGP_EL1, 1'h1, 1'h0, CSGP_TRAP2);
        trapx(12'h23e, CSGP_EL1, 1'h1, 1'h0, CSGP_TRAP2);
        trapx(12'h13e, CSGP_EL1, 1'h1, 1'h0, CSGP_TRAP2);
        run(12'h13e, mk(CSGP_EL1, 1'h1, 1'h0, 1'h0, D), CSGP_TRAP2,
            PN);
        trapx(12'h01e, CSGP_EL1, 1'h1, 1'h0, CSGP_UNDEF);
        trapx(12'h02e, CSGP_EL2, 1'h1, 1'h0, CSGP_UNDEF);
        trapx(12'h036, CSGP_EL3, 1'h0, 1'h0, CSGP_UNDEF);
        trapx(12'h0fe, CSGP_EL1, 1'h1, 1'h0, CSGP_TRAP3);
        trapx(12'h8fe, CSGP_EL1, 1'h1, 1'h0, CSGP_TRAP2);
        trapx(12'h0fe, CSGP_EL2, 1'h1, 1'h0, CSGP_TRAP3);
        trapx(12'h0fe, CSGP_EL1, 1'h0, 1'h0, CSGP_TRAP3);
    endtask

    task automatic t_enable();
        trapx(12'h03a, CSGP_EL1, 1'h1, 1'h1, CSGP_TRAP2);
        trapx(12'h03c, CSGP_EL1, 1'h0, 1'h1, CSGP_TRAP3);
        trapx(12'h03c, CSGP_EL2, 1'h1, 1'h1, CSGP_TRAP3);
        trapx(12'h03c, CSGP_EL1, 1'h1, 1'h1, CSGP_TRAP3);
        trapx(12'h038, CSGP_EL1, 1'h1, 1'h1, CSGP_TRAP2);
        trapx(12'h03e, CSGP_EL1, 1'h1, 1'h1, CSGP_OK);
    endtask

    // unknown encoding followed at once by a good write
    task automatic t_b2b();
        csgp_req_t r;
        r = mk(CSGP_EL1, 1'h0, 1'h1, 1'h0, D);
        r.crm = 4'h0;
        @(posedge clk);
        req <= r;
        @(posedge clk);
        req <= mk(CSGP_EL1, 1'h0, 1'h1, 1'h0, D);
        #1;
        chk_res(CSGP_UNDEF);
        chk_pkt(PN);
        @(posedge clk);
        req.valid <= 1'h0;
        #1;
        chk_res(CSGP_OK);
        chk_pkt(expk(1'h1, 1'h0, D));
        issued++;
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // clock, watchdog, main sequence
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (2000) @(posedge clk);
        num_errors++;
        complete_run();
    end

    initial begin
        rst = 1'h1;
        req = '0;
        ctrl = 12'h03e;
        num_errors = 0;
        checked = 0;
        issued = 0;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        t_fields();
        t_grp0();
        t_traps();
        t_enable();
        t_b2b();
        repeat (2) @(posedge clk);
        chk_cnt(issued);
        complete_run();
    end
endmodule
